// ---- pkg/bfsp_link_if.sv ----
// Purpose : PWM pin and register port
// Assumes : Both ends on aclk
// Notes   : Ack one cycle after request
interface bfsp_link_if;
   logic       pwm_pin;
   logic       reg_req;
   logic       reg_we;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_ack;
   logic [7:0] reg_rdata;
   modport dev  (input pwm_pin, input reg_req, input reg_we, input reg_addr, input reg_wdata,
                 output reg_ack, output reg_rdata);
   modport host (output pwm_pin, output reg_req, output reg_we, output reg_addr, output reg_wdata,
                 input reg_ack, input reg_rdata);
endinterface : bfsp_link_if

// ---- pkg/bfsp_map.svh ----
// Purpose : Constants of the boost sampler
// Assumes : 20 MHz aclk
// Notes   : Definitions only
// Function
// RULE1 - Fixed mode: one bit picks 500k or 1M
// RULE2 - Software sets inductor field to fitted inductor
// RULE3 - Integral and proportional gain fields, defaults 01/11
// RULE4 - 250 kHz only in auto, duty capped 50%
// RULE5 - Thresholds compared to brightness upper byte
// RULE6 - Auto: below low threshold runs 250 kHz
// RULE7 - Auto: between thresholds runs 500 kHz
// RULE8 - Auto: at or above high runs 1 MHz
// RULE9 - Auto active when either threshold nonzero
// RULE10 - Software may start from example thresholds
// RULE11 - Sample PWM input into 11-bit code
// RULE12 - Two bits select one of three rates
// RULE13 - Host drives PWM between 50 Hz and 50 kHz; host period_q is 16 bits, so no slower than about 305 Hz
// RULE14 - Resolution limited by sample period versus pulse
// RULE15 - Lowest rate resolution falls with input frequency
// RULE16 - No pulse until timeout turns boost off
// RULE17 - Code readable as low byte, high three bits
// RULE18 - Count high and period ticks, scale ratio
// RULE19 - Apply new frequency at switching-cycle boundary
`ifndef BFSP_MAP_SVH
`define BFSP_MAP_SVH

`define BFSP_REG_CFG1 8'h02
`define BFSP_REG_CFG2 8'h03
`define BFSP_REG_BRT_HI 8'h05
`define BFSP_REG_AF_LOW 8'h06
`define BFSP_REG_AF_HIGH 8'h07
`define BFSP_REG_OPT2 8'h11
`define BFSP_REG_CODE_LO 8'h12
`define BFSP_REG_CODE_HI 8'h13

`define BFSP_CFG1_PWM_EN 0
`define BFSP_CFG1_BOOST_EN 1
`define BFSP_CFG2_FREQ_1M 7
`define BFSP_CFG2_RATE_MID 2
`define BFSP_XRATE_FAST 0
`define BFSP_OPT2_RST 8'h34

`define BFSP_CLK_MHZ 20
`define BFSP_SW_1M_KHZ 1000
`define BFSP_SW_500_KHZ 500
`define BFSP_SW_250_KHZ 250
`define BFSP_SMP_SLOW_MHZ 1
`define BFSP_SMP_MID_MHZ 4
`define BFSP_SMP_FAST_MHZ 24
`define BFSP_TMO_SLOW_US 25000
`define BFSP_TMO_MID_US 3000
`define BFSP_TMO_FAST_US 600
`define BFSP_DUTY_HALF 8'h80
`define BFSP_CODE_FULL 11'h7ff

`define BFSP_H_CTRL 8'h00
`define BFSP_H_PERIOD 8'h04
`define BFSP_H_HIGH 8'h08
`define BFSP_H_CMD 8'h0c
`define BFSP_H_STATUS 8'h10

`endif

// ---- pkg/bfsp_pkg.sv ----
// Purpose : Shared types
// Assumes : None
// Notes   : Constants live in bfsp_map.svh
package bfsp_pkg;
   typedef enum logic [1:0] {BFSP_F250, BFSP_F500, BFSP_F1M} bfsp_freq_type;
   typedef enum logic {BFSP_H_IDLE, BFSP_H_WAIT} bfsp_hst_state_type;
endpackage : bfsp_pkg

// ---- sim/bfsp_link_properties.sv ----
// Purpose : Link checks
// Assumes : aclk, sync low reset
// Notes   : Mirror covers plain registers
module bfsp_link_properties (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       pwm_pin,
   input wire logic       reg_req,
   input wire logic       reg_we,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_ack,
   input wire logic [7:0] reg_rdata
);
   logic [7:0] mir_q [0:31];
   logic [7:0] exp_q;
   logic       plain_rw;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   assign plain_rw = reg_addr inside {8'h05, 8'h06, 8'h07, 8'h11};
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mir_q <= '{17: 8'h34, default: 8'h00};
      else if (reg_req && reg_we && plain_rw)
         mir_q[reg_addr[4:0]] <= reg_wdata;
   end
   always_ff @(posedge aclk)
      exp_q <= mir_q[reg_addr[4:0]];
   // ========
   // Register port
   chk_ack_after_req:
      assert property (reg_req |=> reg_ack) else $error("no ack");
   chk_ack_has_cause:
      assert property (reg_ack |-> $past(reg_req)) else $error("stray ack");
   chk_req_one_cycle:
      assert property (reg_req |=> !reg_req) else $error("long request");
   chk_ack_pulse_only:
      assert property ($rose(reg_ack) |=> $fell(reg_ack)) else $error("long ack");
   chk_rdata_held_idle:
      assert property (!reg_ack |-> $stable(reg_rdata)) else $error("rdata moved");
   chk_rw_readback:
      assert property (reg_req && !reg_we && plain_rw |=> reg_rdata == exp_q) else $error("readback mismatch");
   chk_code_hi_clear:
      assert property (reg_req && !reg_we && reg_addr == 8'h13 |=> reg_rdata[7:3] == 5'h00)
         else $error("code upper bits");
   chk_unmapped_zero:
      assert property (reg_req && !reg_we && reg_addr >= 8'h14 |=> reg_rdata == 8'h00)
         else $error("unmapped read not zero");
   cov_code_hi_read: cover property (reg_req && !reg_we && reg_addr == 8'h13);
   cov_limit_write: cover property (reg_req && reg_we && reg_addr == 8'h06);
   cov_unmapped_read: cover property (reg_req && !reg_we && reg_addr >= 8'h14);
endmodule : bfsp_link_properties

// ---- sim/tb_boost_freq_select_and_pwm_sampler.sv ----
// Purpose : Bench of both ends
// Assumes : aclk 20 MHz, reset held 20 cycles
// Notes   : Timeouts cut to 2000 cycles
module tb_boost_freq_select_and_pwm_sampler;
   timeunit 1ns;
   timeprecision 100ps;
   logic        aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
   logic [7:0]  awa = 8'h00, ara = 8'h00, duty = 8'hff;
   logic [31:0] wd = 32'h0, rd;
   logic        awr, wr, bv, arr, rv, gate, bon;
   logic [1:0]  br, rr, fs, ig, pg, ls;
   logic [10:0] code;
   int          n_mismatch = 0, check_count = 0;
   always #25 aclk = ~aclk;
   bfsp_link_if bfsp_link_if_inst ();
   bfsp_device #(.TMO_SLOW_CYC(2000), .TMO_MID_CYC(2000), .TMO_FAST_CYC(2000)) bfsp_device_inst (
      .aclk(aclk), .aresetn(aresetn), .link(bfsp_link_if_inst.dev), .boost_duty(duty), .boost_gate(gate),
      .boost_on(bon), .freq_sel(fs), .integ_gain(ig), .prop_gain(pg), .l_select(ls), .brightness_code(code));
   bfsp_host bfsp_host_inst (
      .aclk(aclk), .aresetn(aresetn), .link(bfsp_link_if_inst.host), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
   bfsp_link_properties bfsp_link_properties_inst (
      .aclk(aclk), .aresetn(aresetn), .pwm_pin(bfsp_link_if_inst.pwm_pin), .reg_req(bfsp_link_if_inst.reg_req),
      .reg_we(bfsp_link_if_inst.reg_we), .reg_addr(bfsp_link_if_inst.reg_addr),
      .reg_wdata(bfsp_link_if_inst.reg_wdata), .reg_ack(bfsp_link_if_inst.reg_ack),
      .reg_rdata(bfsp_link_if_inst.reg_rdata));
   // ========
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      if (n_mismatch == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   task automatic tmo();
      chk("wait bound", 1'h0, 1'h1);
      wrap_up();
   endtask : tmo
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (awr) awv <= 1'h0;
         if (wr) wv <= 1'h0;
         if (bv) break;
      end
      bry <= 1'h0;
      if (n == 50) tmo();
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (arr) arv <= 1'h0;
         if (rv) break;
      end
      d = rd;
      r = rr;
      rry <= 1'h0;
      if (n == 50) tmo();
   endtask : axi_rd
   // Device register access via command and status
   task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [31:0] s;
      logic [1:0]  r;
      int          n;
      axi_wr(8'h0c, {15'h0000, we, a, d});
      for (n = 0; n < 20; n++)
      begin
         axi_rd(8'h10, s, r);
         if (s[8] === 1'h0) break;
      end
      if (n == 20) tmo();
      q = s[7:0];
   endtask : acc
   task automatic see_freq(input logic [1:0] e);
      for (int n = 0; n < 300 && fs !== e; n++) @(posedge aclk);
      chk("freq_sel", fs, e);
   endtask : see_freq
   // ========
   // Scenarios
   task automatic sc_regs();
      logic [7:0]  q;
      logic [31:0] d;
      logic [1:0]  r;
      chk("integ_gain", ig, 2'h1);
      chk("prop_gain", pg, 2'h3);
      chk("freq_sel", fs, 2'h1);
      acc(1'h0, 8'h11, 8'h00, q);
      chk("option reset", q, 8'h34);
      acc(1'h1, 8'h11, 8'hc4, q);
      chk("l_select", ls, 2'h3);
      chk("prop_gain", pg, 2'h0);
      acc(1'h1, 8'h13, 8'hff, q);
      acc(1'h0, 8'h13, 8'h00, q);
      chk("code upper", q[7:3], 5'h00);
      acc(1'h0, 8'h20, 8'h00, q);
      chk("unmapped", q, 8'h00);
      axi_rd(8'h40, d, r);
      chk("rresp", r, 2'h2);
   endtask : sc_regs
   task automatic sc_freq();
      logic [7:0] q;
      logic [7:0] b [6] = '{8'h3e, 8'h3f, 8'h40, 8'h53, 8'h54, 8'hff};
      logic [1:0] e [6] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
      int         h = 0;
      acc(1'h1, 8'h02, 8'h02, q);
      acc(1'h1, 8'h03, 8'h80, q);
      see_freq(2'h2);
      acc(1'h1, 8'h03, 8'h00, q);
      see_freq(2'h1);
      acc(1'h1, 8'h06, 8'h3f, q);
      acc(1'h1, 8'h07, 8'h54, q);
      for (int i = 0; i < 6; i++)
      begin
         acc(1'h1, 8'h05, b[i], q);
         see_freq(e[i]);
      end
      acc(1'h1, 8'h05, 8'h3e, q);
      see_freq(2'h0);
      // 80 cycles span one 250 kHz period
      repeat (80)
      begin
         @(posedge aclk);
         h += (gate === 1'h1);
      end
      chk("boost_on", bon, 1'h1);
      chk("duty cap", h <= 40, 1'h1);
      acc(1'h1, 8'h03, 8'h80, q);
      acc(1'h1, 8'h06, 8'h00, q);
      acc(1'h1, 8'h05, 8'h10, q);
      see_freq(2'h1);
      acc(1'h1, 8'h07, 8'h00, q);
      see_freq(2'h2);
   endtask : sc_freq
   // Slow sampling may gain or lose one high tick
   task automatic rate(input logic [7:0] c3, input logic [7:0] x12, input int st);
      logic [7:0]  q;
      logic [10:0] lo, hi, e;
      acc(1'h1, 8'h03, c3, q);
      acc(1'h1, 8'h12, x12, q);
      repeat (1300) @(posedge aclk);
      lo = 11'((110 / st) * 2047 / (400 / st));
      hi = 11'(((110 + st - 1) / st) * 2047 / (400 / st));
      e = (code === hi) ? hi : lo;
      chk("brightness_code", code, e);
      acc(1'h0, 8'h12, 8'h00, q);
      chk("code lower", q, e[7:0]);
      acc(1'h0, 8'h13, 8'h00, q);
      chk("code upper", q, {5'h00, e[10:8]});
   endtask : rate
   task automatic sc_pwm();
      logic [7:0] q;
      int         n;
      acc(1'h1, 8'h02, 8'h03, q);
      axi_wr(8'h04, 32'h190);
      axi_wr(8'h08, 32'h6e);
      axi_wr(8'h00, 32'h1);
      rate(8'h00, 8'h00, 20);
      rate(8'h04, 8'h00, 5);
      rate(8'h00, 8'h01, 1);
      chk("boost_on", bon, 1'h1);
      axi_wr(8'h00, 32'h0);
      for (n = 0; n < 3000 && bon !== 1'h0; n++) @(posedge aclk);
      chk("boost_on", bon, 1'h0);
   endtask : sc_pwm
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      sc_regs();
      sc_freq();
      sc_pwm();
      wrap_up();
   end
endmodule : tb_boost_freq_select_and_pwm_sampler

// ---- src/bfsp_device.sv ----
// Purpose : Boost frequency select and PWM sampler
// Assumes : Inputs synchronous to aclk
// Notes   : Code updates two cycles after divide
`include "bfsp_map.svh"
module bfsp_device #(
   parameter int TMO_SLOW_CYC = `BFSP_TMO_SLOW_US * `BFSP_CLK_MHZ,
   parameter int TMO_MID_CYC  = `BFSP_TMO_MID_US * `BFSP_CLK_MHZ,
   parameter int TMO_FAST_CYC = `BFSP_TMO_FAST_US * `BFSP_CLK_MHZ
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   bfsp_link_if.dev        link,
   input  wire logic [7:0] boost_duty,
   output logic            boost_gate,
   output logic            boost_on,
   output logic [1:0]      freq_sel,
   output logic [1:0]      integ_gain,
   output logic [1:0]      prop_gain,
   output logic [1:0]      l_select,
   output logic [10:0]     brightness_code
);
   // ========
   // Timing derived from the clock rate
   localparam int SW_1M_CYC  = `BFSP_CLK_MHZ * 1000 / `BFSP_SW_1M_KHZ;
   localparam int SW_500_CYC = `BFSP_CLK_MHZ * 1000 / `BFSP_SW_500_KHZ;
   localparam int SW_250_CYC = `BFSP_CLK_MHZ * 1000 / `BFSP_SW_250_KHZ;
   localparam int SMP_SLOW   = `BFSP_CLK_MHZ / `BFSP_SMP_SLOW_MHZ;
   localparam int SMP_MID    = `BFSP_CLK_MHZ / `BFSP_SMP_MID_MHZ;
   // 24 MHz exceeds aclk: one sample per clock
   localparam int SMP_FAST   = (`BFSP_CLK_MHZ / `BFSP_SMP_FAST_MHZ) < 1 ? 1 : `BFSP_CLK_MHZ / `BFSP_SMP_FAST_MHZ;

   // ========
   // Registers
   logic [7:0] cfg1_q;
   logic [7:0] cfg2_q;
   logic [7:0] brt_hi_q;
   logic [7:0] af_low_q;
   logic [7:0] af_high_q;
   logic [7:0] opt2_q;
   logic       xrate_q;
   logic [7:0] rdata_d;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg1_q    <= 8'h00;
         cfg2_q    <= 8'h00;
         brt_hi_q  <= 8'h00;
         af_low_q  <= 8'h00;
         af_high_q <= 8'h00;
         opt2_q    <= `BFSP_OPT2_RST; // RULE3
         xrate_q   <= 1'b0;
      end
      else if (link.reg_req && link.reg_we)
      begin
         case (link.reg_addr)
            `BFSP_REG_CFG1    : cfg1_q    <= link.reg_wdata;
            `BFSP_REG_CFG2    : cfg2_q    <= link.reg_wdata;
            `BFSP_REG_BRT_HI  : brt_hi_q  <= link.reg_wdata;
            `BFSP_REG_AF_LOW  : af_low_q  <= link.reg_wdata;
            `BFSP_REG_AF_HIGH : af_high_q <= link.reg_wdata;
            `BFSP_REG_OPT2    : opt2_q    <= link.reg_wdata;
            `BFSP_REG_CODE_LO : xrate_q   <= link.reg_wdata[`BFSP_XRATE_FAST];
            default           : ;
         endcase
      end
   end

   always_comb
   begin
      case (link.reg_addr)
         `BFSP_REG_CFG1    : rdata_d = cfg1_q;
         `BFSP_REG_CFG2    : rdata_d = cfg2_q;
         `BFSP_REG_BRT_HI  : rdata_d = brt_hi_q;
         `BFSP_REG_AF_LOW  : rdata_d = af_low_q;
         `BFSP_REG_AF_HIGH : rdata_d = af_high_q;
         `BFSP_REG_OPT2    : rdata_d = opt2_q;
         `BFSP_REG_CODE_LO : rdata_d = brightness_code[7:0];         // RULE17
         `BFSP_REG_CODE_HI : rdata_d = {5'h00, brightness_code[10:8]}; // RULE17
         default           : rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         link.reg_ack   <= 1'b0;
         link.reg_rdata <= 8'h00;
      end
      else
      begin
         link.reg_ack   <= link.reg_req;
         link.reg_rdata <= link.reg_req ? rdata_d : link.reg_rdata;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         integ_gain <= 2'b01;
         prop_gain  <= 2'b11;
         l_select   <= 2'b00;
      end
      else
      begin
         integ_gain <= opt2_q[3:2]; // RULE3
         prop_gain  <= opt2_q[5:4]; // RULE3
         l_select   <= opt2_q[7:6]; // RULE2
      end
   end

   // ========
   // Frequency choice
   bfsp_pkg::bfsp_freq_type freq_d;
   bfsp_pkg::bfsp_freq_type freq_q;
   logic                    auto_en;

   assign auto_en = (af_low_q != 8'h00) || (af_high_q != 8'h00); // RULE9

   always_comb
   begin
      if (!auto_en)
         freq_d = cfg2_q[`BFSP_CFG2_FREQ_1M] ? bfsp_pkg::BFSP_F1M : bfsp_pkg::BFSP_F500; // RULE1
      else if (brt_hi_q >= af_high_q) // RULE5
         freq_d = bfsp_pkg::BFSP_F1M; // RULE8
      else if (brt_hi_q < af_low_q)
         freq_d = bfsp_pkg::BFSP_F250; // RULE6 RULE4
      else
         freq_d = bfsp_pkg::BFSP_F500; // RULE7
   end

   // ========
   // Switching cycle generator
   logic [6:0]  sw_cnt_q;
   logic [6:0]  sw_per;
   logic [7:0]  duty_lim;
   logic [14:0] on_prod;
   logic        boost_run;
   logic        timed_out_q;

   always_comb
   begin
      case (freq_q)
         bfsp_pkg::BFSP_F250 : sw_per = 7'(SW_250_CYC);
         bfsp_pkg::BFSP_F500 : sw_per = 7'(SW_500_CYC);
         default             : sw_per = 7'(SW_1M_CYC);
      endcase
   end

   assign duty_lim = (freq_q == bfsp_pkg::BFSP_F250 && boost_duty > `BFSP_DUTY_HALF)
                     ? `BFSP_DUTY_HALF : boost_duty; // RULE4
   assign on_prod  = {7'h00, duty_lim} * {8'h00, sw_per};
   assign boost_run = cfg1_q[`BFSP_CFG1_BOOST_EN] && !(cfg1_q[`BFSP_CFG1_PWM_EN] && timed_out_q); // RULE16

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sw_cnt_q   <= 7'h00;
         freq_q     <= bfsp_pkg::BFSP_F500;
         boost_gate <= 1'b0;
         boost_on   <= 1'b0;
         freq_sel   <= 2'h0;
      end
      else
      begin
         boost_on <= boost_run;
         if (sw_cnt_q >= sw_per - 7'h01)
         begin
            sw_cnt_q <= 7'h00;
            freq_q   <= freq_d; // RULE19
         end
         else
         begin
            sw_cnt_q <= sw_cnt_q + 7'h01;
         end
         freq_sel   <= freq_q;
         boost_gate <= boost_run && (sw_cnt_q < on_prod[14:8]); // RULE4
      end
   end

   // ========
   // PWM sampler
   logic [4:0]  tick_cnt_q;
   logic [4:0]  tick_per;
   logic        tick;
   logic        smp_q;
   logic        seen_q;
   logic [15:0] hi_cnt_q;
   logic [15:0] per_cnt_q;
   logic [18:0] tmo_cnt_q;
   logic [18:0] tmo_lim;
   logic        rise;
   logic        div_start;
   logic        div_done;
   logic [10:0] div_quot;

   always_comb
   begin
      if (xrate_q) // RULE12
      begin
         tick_per = 5'(SMP_FAST);
         tmo_lim  = 19'(TMO_FAST_CYC);
      end
      else if (cfg2_q[`BFSP_CFG2_RATE_MID])
      begin
         tick_per = 5'(SMP_MID);
         tmo_lim  = 19'(TMO_MID_CYC);
      end
      else
      begin
         tick_per = 5'(SMP_SLOW);
         tmo_lim  = 19'(TMO_SLOW_CYC);
      end
   end

   assign tick      = (tick_cnt_q >= tick_per - 5'h01);
   assign rise      = tick && link.pwm_pin && !smp_q;
   assign div_start = rise && seen_q && (per_cnt_q != 16'h0000);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_cnt_q <= 5'h00;
         smp_q      <= 1'b0;
         seen_q     <= 1'b0;
         hi_cnt_q   <= 16'h0000;
         per_cnt_q  <= 16'h0000;
      end
      else
      begin
         tick_cnt_q <= tick ? 5'h00 : tick_cnt_q + 5'h01;
         if (tick) // RULE11 RULE14
         begin
            smp_q <= link.pwm_pin;
            if (rise) // RULE18
            begin
               seen_q    <= 1'b1;
               hi_cnt_q  <= 16'h0001;
               per_cnt_q <= 16'h0001;
            end
            else if (per_cnt_q != 16'hffff)
            begin
               per_cnt_q <= per_cnt_q + 16'h0001;
               hi_cnt_q  <= hi_cnt_q + {15'h0000, link.pwm_pin};
            end
         end
      end
   end

   // Edge-free time is counted in clocks so a rate change cannot stretch it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tmo_cnt_q   <= 19'h00000;
         timed_out_q <= 1'b0;
      end
      else if (rise || !cfg1_q[`BFSP_CFG1_PWM_EN])
      begin
         tmo_cnt_q   <= 19'h00000;
         timed_out_q <= 1'b0;
      end
      else if (tmo_cnt_q >= tmo_lim) // RULE16
      begin
         timed_out_q <= 1'b1;
      end
      else
      begin
         tmo_cnt_q <= tmo_cnt_q + 19'h00001;
      end
   end

   bfsp_div #(
      .NW (26),
      .DW (16),
      .QW (11)
   ) u_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (div_start),
      .num     (26'(hi_cnt_q) * 26'(`BFSP_CODE_FULL)), // RULE18 RULE15
      .den     (per_cnt_q),
      .done    (div_done),
      .quot    (div_quot)
   );

   logic div_done_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_done_q      <= 1'b0;
         brightness_code <= 11'h000;
      end
      else
      begin
         div_done_q <= div_done;
         if (div_done_q)
            brightness_code <= div_quot; // RULE11
      end
   end
endmodule : bfsp_device

// ---- src/bfsp_div.sv ----
// Purpose : Restoring divider, one bit per clock
// Assumes : den nonzero, quotient fits QW bits
// Notes   : Saturates on overflow
module bfsp_div #(
   parameter int NW = 26,
   parameter int DW = 16,
   parameter int QW = 11
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          start,
   input  wire logic [NW-1:0] num,
   input  wire logic [DW-1:0] den,
   output logic               done,
   output logic [QW-1:0]      quot
);
   logic [NW-1:0] q_q;
   logic [DW:0]   rem_q;
   logic [DW-1:0] den_q;
   logic [5:0]    cnt_q;
   logic [DW:0]   rem_sh;

   assign rem_sh = {rem_q[DW-1:0], q_q[NW-1]};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q_q   <= '0;
         rem_q <= '0;
         den_q <= '0;
         cnt_q <= 6'h00;
         done  <= 1'b0;
         quot  <= '0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            q_q   <= num;
            rem_q <= '0;
            den_q <= den;
            cnt_q <= 6'(NW);
         end
         else if (cnt_q != 6'h00)
         begin
            cnt_q <= cnt_q - 6'h01;
            if (rem_sh >= {1'b0, den_q})
            begin
               rem_q <= rem_sh - {1'b0, den_q};
               q_q   <= {q_q[NW-2:0], 1'b1};
            end
            else
            begin
               rem_q <= rem_sh;
               q_q   <= {q_q[NW-2:0], 1'b0};
            end
            done <= (cnt_q == 6'h01);
         end
         else if (done)
            quot <= (|q_q[NW-1:QW]) ? '1 : q_q[QW-1:0];
      end
   end
endmodule : bfsp_div

// ---- src/bfsp_host.sv ----
// Purpose : AXI4-Lite register controller
// Assumes : One AXI write and one read at a time
// Notes   : Commands dropped while busy
`include "bfsp_map.svh"
module bfsp_host (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   bfsp_link_if.host        link,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // ========
   // AXI4-Lite slave
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic        aw_got_q;
   logic        w_got_q;
   logic        do_wr;
   logic        run_q;
   logic [15:0] period_q;
   logic [15:0] high_q;
   logic [7:0]  rd_byte_q;
   bfsp_pkg::bfsp_hst_state_type st_q;

   assign do_wr = aw_got_q && w_got_q && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h00000000;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_q      <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_q      <= 1'b1;
            wdata_q      <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (do_wr)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q <= `BFSP_H_STATUS && awaddr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         run_q    <= 1'b0;
         period_q <= 16'h0000;
         high_q   <= 16'h0000;
      end
      else if (do_wr && s_axi_wstrb[0])
      begin
         case (awaddr_q)
            `BFSP_H_CTRL   : run_q <= wdata_q[0];
            `BFSP_H_PERIOD : period_q <= wdata_q[15:0];
            `BFSP_H_HIGH   : high_q <= wdata_q[15:0];
            default        : ;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= 2'h0;
         case (s_axi_araddr)
            `BFSP_H_CTRL   : s_axi_rdata <= {31'h00000000, run_q};
            `BFSP_H_PERIOD : s_axi_rdata <= {16'h0000, period_q};
            `BFSP_H_HIGH   : s_axi_rdata <= {16'h0000, high_q};
            `BFSP_H_CMD    : s_axi_rdata <= 32'h00000000;
            `BFSP_H_STATUS : s_axi_rdata <= {23'h000000, st_q == bfsp_pkg::BFSP_H_WAIT, rd_byte_q};
            default        :
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ========
   // Register port toward the device
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q           <= bfsp_pkg::BFSP_H_IDLE;
         link.reg_req   <= 1'b0;
         link.reg_we    <= 1'b0;
         link.reg_addr  <= 8'h00;
         link.reg_wdata <= 8'h00;
         rd_byte_q      <= 8'h00;
      end
      else
      begin
         link.reg_req <= 1'b0;
         case (st_q)
            bfsp_pkg::BFSP_H_IDLE :
            begin
               // Software picks these values; this end only carries them
               if (do_wr && awaddr_q == `BFSP_H_CMD) // RULE2 RULE10
               begin
                  link.reg_req   <= 1'b1;
                  link.reg_we    <= wdata_q[16];
                  link.reg_addr  <= wdata_q[15:8];
                  link.reg_wdata <= wdata_q[7:0];
                  st_q           <= bfsp_pkg::BFSP_H_WAIT;
               end
            end
            bfsp_pkg::BFSP_H_WAIT :
            begin
               if (link.reg_ack)
               begin
                  rd_byte_q <= link.reg_rdata;
                  st_q      <= bfsp_pkg::BFSP_H_IDLE;
               end
            end
            default : st_q <= bfsp_pkg::BFSP_H_IDLE;
         endcase
      end
   end

   // ========
   // PWM pin generator; software keeps the period within 50 Hz to 50 kHz
   logic [15:0] pwm_cnt_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pwm_cnt_q    <= 16'h0000;
         link.pwm_pin <= 1'b0;
      end
      else if (!run_q || period_q == 16'h0000)
      begin
         pwm_cnt_q    <= 16'h0000;
         link.pwm_pin <= 1'b0;
      end
      else
      begin
         pwm_cnt_q    <= (pwm_cnt_q >= period_q - 16'h0001) ? 16'h0000 : pwm_cnt_q + 16'h0001; // RULE13
         link.pwm_pin <= (pwm_cnt_q < high_q); // RULE14
      end
   end
endmodule : bfsp_host
